//--- rtl/ofl_core.sv
// Operand-field decode, 16-bit load sequencer and register-addressed 8-bit arithmetic
// Notes on behaviour
// - byte field 000..101 picks high, low of pair zero, one, two in turn.
// - arith pair 11 is stack pointer; stack pair 11 is accumulator-flags.
// - condition field tests zero, carry, parity/overflow, sign, clear then set.
// - relative condition field tests zero clear/set, carry clear/set.
// - restart target is field value times eight.
// - immediate pair load takes 4,3,3 T states, flags kept.
// - sixteen-bit operands arrive low byte first, then high byte.
// - prefix 11x11101 redirects pair to first index (x=0) or second (x=1).
// - immediate index load takes 4,4,3,3 T states.
// - opcode 00100010 stores pair two low then high, 4,3,3,3,3 T states.
// - extended or index direct store takes 4,4,3,3,3,3 T states.
// - stack pointer from pair two takes one 6-T-state cycle, flags kept.
// - stack pointer from index takes 4 then 6 T states.
// - add-side decimal adjust adds 00,06,60,66; carry for 60 and 66.
// - subtract-side decimal adjust adds 00,FA,A0,9A; carry kept.
// - add sets sign, zero, half carry bit 3, carry bit 7, overflow; clears N.
// - add-with-carry adds carry in, flags as add.
// - subtract sets sign, zero, borrow flags, overflow and N.
// - subtract-with-borrow encoded 10011 rrr, flags as subtract.
// - register add or subtract finishes in one 4-T-state cycle.
`timescale 1ns/1ns
`default_nettype none
`include "ofl_cfg.svh"
module ofl_core (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic byte_valid,
   input wire logic [7:0] byte_in,
   input wire logic [7:0] byte_reg_in,
   input wire logic [2:0] cond_field,
   input wire logic [1:0] rel_cond_field,
   input wire logic [2:0] rst_field,
   input wire logic [1:0] pair_field_stack,
   input wire logic adjust_req,
   output logic byte_ready,
   output logic [7:0] accum,
   output logic [7:0] flags,
   output logic [15:0] pair_zero,
   output logic [15:0] pair_one,
   output logic [15:0] pair_two,
   output logic [15:0] stack_pointer,
   output logic [15:0] index_first,
   output logic [15:0] index_second,
   output logic [2:0] byte_sel,
   output logic [2:0] stack_pair_sel,
   output logic cond_true,
   output logic rel_cond_true,
   output logic [15:0] rst_target,
   output logic mem_wr,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic [2:0] t_states,
   output logic mcycle_done,
   output logic instr_done
);
   ofl_pkg::ofl_state_t state;
   ofl_pkg::ofl_state_t next_state;
   ofl_pkg::ofl_pair_t dest;
   logic is_store;
   logic [7:0] lo_byte;
   logic [15:0] addr;
   logic [2:0] tcnt;
   logic [2:0] tlen;
   logic [2:0] next_tlen;
   logic [2:0] cur_len;
   logic step;
   logic pfx_idx;
   logic pfx_ed;
   logic pfx_sel;
   logic alu_fire;
   ofl_alu_if alu_bus ();

   ofl_alu u_alu (
      .a(alu_bus)
   );

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // arithmetic pair decode
   function automatic ofl_pkg::ofl_pair_t arith_pair(input logic [1:0] f, input logic use0, input logic use1);
      ofl_pkg::ofl_pair_t p;
      p = ofl_pkg::ofl_pair_t'({1'b0, f});
      if (f == 2'b10 && use0) begin
         p = ofl_pkg::OFL_REG_IDX0;
      end else if (f == 2'b10 && use1) begin
         p = ofl_pkg::OFL_REG_IDX1;
      end
      return p;
   endfunction

   function automatic logic [15:0] pair_value(input ofl_pkg::ofl_pair_t p, input logic [15:0] p0, input logic [15:0] p1,
                                              input logic [15:0] p2, input logic [15:0] sp,
                                              input logic [15:0] x0, input logic [15:0] x1);
      logic [15:0] v;
      v = 16'h0000;
      unique case (p)
         ofl_pkg::OFL_REG_PAIR0: v = p0;
         ofl_pkg::OFL_REG_PAIR1: v = p1;
         ofl_pkg::OFL_REG_PAIR2: v = p2;
         ofl_pkg::OFL_REG_STK: v = sp;
         ofl_pkg::OFL_REG_IDX0: v = x0;
         ofl_pkg::OFL_REG_IDX1: v = x1;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // ----------------------------------------
   // Timing of machine cycles
   // ----------------------------------------
   // stack copy stretches own cycle
   assign cur_len = ((state == ofl_pkg::OFL_ST_FETCH || (state == ofl_pkg::OFL_ST_PFX && pfx_idx))
                     && byte_in == `OFL_OP_MOV_STK) ? `OFL_T_SPLD : tlen;
   assign step = clk_en && (tcnt == cur_len - 3'd1);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tcnt <= 3'd0;
         tlen <= `OFL_T_FETCH;
      end else if (clk_en) begin
         if (step) begin
            tcnt <= 3'd0;
            tlen <= next_tlen;
         end else begin
            tcnt <= tcnt + 3'd1;
         end
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_tlen = `OFL_T_MEM;
      unique case (state)
         ofl_pkg::OFL_ST_FETCH: begin
            if ((byte_in & `OFL_OP_IDX_MASK) == `OFL_OP_IDX_PREFIX || byte_in == `OFL_OP_ED_PREFIX) begin
               next_state = ofl_pkg::OFL_ST_PFX;
               next_tlen = `OFL_T_FETCH;
            end else if ((byte_in & `OFL_OP_LDIMM_MASK) == `OFL_OP_LDIMM_PAIR || byte_in == `OFL_OP_ST_PAIR_TWO) begin
               next_state = ofl_pkg::OFL_ST_LO;
            end else begin
               next_tlen = `OFL_T_FETCH;
               next_state = ofl_pkg::OFL_ST_FETCH;
            end
         end
         ofl_pkg::OFL_ST_PFX: begin
            if (pfx_idx && byte_in == `OFL_OP_MOV_STK) begin
               next_state = ofl_pkg::OFL_ST_FETCH;
               next_tlen = `OFL_T_FETCH;
            end else if ((pfx_idx && (byte_in == `OFL_OP_LDIMM_PAIR + 8'h20 || byte_in == `OFL_OP_ST_PAIR_TWO))
                         || (pfx_ed && (byte_in & `OFL_OP_ED_STORE_MASK) == `OFL_OP_ED_STORE)) begin
               next_state = ofl_pkg::OFL_ST_LO;
            end else begin
               next_state = ofl_pkg::OFL_ST_FETCH;
               next_tlen = `OFL_T_FETCH;
            end
         end
         ofl_pkg::OFL_ST_LO: next_state = ofl_pkg::OFL_ST_HI;
         ofl_pkg::OFL_ST_HI: begin
            next_state = is_store ? ofl_pkg::OFL_ST_WRLO : ofl_pkg::OFL_ST_FETCH;
            next_tlen = is_store ? `OFL_T_MEM : `OFL_T_FETCH;
         end
         ofl_pkg::OFL_ST_WRLO: next_state = ofl_pkg::OFL_ST_WRHI;
         ofl_pkg::OFL_ST_WRHI: begin
            next_state = ofl_pkg::OFL_ST_FETCH;
            next_tlen = `OFL_T_FETCH;
         end
         ofl_pkg::OFL_ST_SPX: begin
            next_state = ofl_pkg::OFL_ST_FETCH;
            next_tlen = `OFL_T_FETCH;
         end
         default: begin
            next_state = ofl_pkg::OFL_ST_FETCH;
            next_tlen = `OFL_T_FETCH;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state <= ofl_pkg::OFL_ST_FETCH;
         pfx_idx <= 1'b0;
         pfx_ed <= 1'b0;
         pfx_sel <= 1'b0;
         dest <= ofl_pkg::OFL_REG_PAIR0;
         is_store <= 1'b0;
         lo_byte <= 8'h00;
         addr <= 16'h0000;
      end else if (step) begin
         state <= next_state;
         unique case (state)
            ofl_pkg::OFL_ST_FETCH: begin
               pfx_idx <= (byte_in & `OFL_OP_IDX_MASK) == `OFL_OP_IDX_PREFIX;
               pfx_ed <= byte_in == `OFL_OP_ED_PREFIX;
               pfx_sel <= byte_in[5];
               dest <= arith_pair(byte_in[5:4], 1'b0, 1'b0);
               is_store <= byte_in == `OFL_OP_ST_PAIR_TWO;
            end
            ofl_pkg::OFL_ST_PFX: begin
               dest <= pfx_ed ? arith_pair(byte_in[5:4], 1'b0, 1'b0) : arith_pair(2'b10, !pfx_sel, pfx_sel);
               is_store <= pfx_ed || byte_in == `OFL_OP_ST_PAIR_TWO;
            end
            ofl_pkg::OFL_ST_LO: lo_byte <= byte_in;
            ofl_pkg::OFL_ST_HI: addr <= {byte_in, lo_byte};
            ofl_pkg::OFL_ST_WRLO: addr <= addr + 16'h0001;
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // Register array writes
   // ----------------------------------------
   logic [15:0] src;
   assign src = pair_value(dest, pair_zero, pair_one, pair_two, stack_pointer, index_first, index_second);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pair_zero <= 16'h0000;
         pair_one <= 16'h0000;
         pair_two <= 16'h0000;
         stack_pointer <= 16'h0000;
         index_first <= 16'h0000;
         index_second <= 16'h0000;
      end else if (step) begin
         if (state == ofl_pkg::OFL_ST_HI && !is_store) begin
            unique case (dest)
               ofl_pkg::OFL_REG_PAIR0: pair_zero <= {byte_in, lo_byte};
               ofl_pkg::OFL_REG_PAIR1: pair_one <= {byte_in, lo_byte};
               ofl_pkg::OFL_REG_PAIR2: pair_two <= {byte_in, lo_byte};
               ofl_pkg::OFL_REG_STK: stack_pointer <= {byte_in, lo_byte};
               ofl_pkg::OFL_REG_IDX0: index_first <= {byte_in, lo_byte};
               ofl_pkg::OFL_REG_IDX1: index_second <= {byte_in, lo_byte};
               default: begin
               end
            endcase
         end
         if (state == ofl_pkg::OFL_ST_FETCH && byte_in == `OFL_OP_MOV_STK) begin
            stack_pointer <= pair_two;
         end
         if (state == ofl_pkg::OFL_ST_PFX && pfx_idx && byte_in == `OFL_OP_MOV_STK) begin
            stack_pointer <= pfx_sel ? index_second : index_first;
         end
      end
   end

   // ----------------------------------------
   // Memory write port for direct stores
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mem_wr <= 1'b0;
         mem_addr <= 16'h0000;
         mem_wdata <= 8'h00;
      end else if (clk_en) begin
         mem_wr <= 1'b0;
         if (step && (state == ofl_pkg::OFL_ST_WRLO || state == ofl_pkg::OFL_ST_WRHI)) begin
            // low byte at address, high at address plus one
            mem_wr <= 1'b1;
            mem_addr <= addr;
            mem_wdata <= (state == ofl_pkg::OFL_ST_WRLO) ? src[7:0] : src[15:8];
         end
      end
   end

   // ----------------------------------------
   // Accumulator and flags
   // ----------------------------------------
   assign alu_fire = step && state == ofl_pkg::OFL_ST_FETCH && (((byte_in & `OFL_OP_ALU_MASK) == `OFL_OP_ALU_BASE)
                     || adjust_req);
   assign alu_bus.op = adjust_req ? ofl_pkg::OFL_ALU_DECADJ : ofl_pkg::ofl_alu_op_t'({1'b0, byte_in[4:3]});
   assign alu_bus.acc = accum;
   assign alu_bus.operand = byte_reg_in;
   assign alu_bus.flags_in = flags;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         accum <= 8'h00;
         flags <= 8'h00;
      end else if (alu_fire) begin
         accum <= alu_bus.result;
         flags <= alu_bus.flags_out;
      end
   end

   // ----------------------------------------
   // Field decode outputs
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         byte_sel <= 3'd0;
         stack_pair_sel <= 3'd0;
         cond_true <= 1'b0;
         rel_cond_true <= 1'b0;
         rst_target <= 16'h0000;
         byte_ready <= 1'b0;
         t_states <= 3'd0;
         mcycle_done <= 1'b0;
         instr_done <= 1'b0;
      end else if (clk_en) begin
         byte_sel <= byte_in[2:0];
         stack_pair_sel <= (pair_field_stack == 2'b11) ? ofl_pkg::OFL_REG_ACCF : {1'b0, pair_field_stack};
         unique case (cond_field[2:1])
            2'b00: cond_true <= flags[`OFL_FLAG_Z] == cond_field[0];
            2'b01: cond_true <= flags[`OFL_FLAG_C] == cond_field[0];
            2'b10: cond_true <= flags[`OFL_FLAG_PV] == cond_field[0];
            2'b11: cond_true <= flags[`OFL_FLAG_S] == cond_field[0];
         endcase
         rel_cond_true <= (rel_cond_field[1] ? flags[`OFL_FLAG_C] : flags[`OFL_FLAG_Z]) == rel_cond_field[0];
         rst_target <= {10'h000, rst_field, 3'b000};
         byte_ready <= step;
         t_states <= cur_len;
         mcycle_done <= step;
         instr_done <= step && next_state == ofl_pkg::OFL_ST_FETCH;
      end
   end
endmodule
`default_nettype wire

//--- rtl/ofl_cfg.svh
// Constants for the operand-field decoder, 16-bit loads and 8-bit arithmetic
`ifndef OFL_CFG_SVH
`define OFL_CFG_SVH
// Flag bit positions
`define OFL_FLAG_S 7
`define OFL_FLAG_Z 6
`define OFL_FLAG_H 4
`define OFL_FLAG_PV 2
`define OFL_FLAG_N 1
`define OFL_FLAG_C 0
// Opcodes and prefixes
`define OFL_OP_LDIMM_PAIR 8'h01
`define OFL_OP_LDIMM_MASK 8'hcf
`define OFL_OP_ST_PAIR_TWO 8'h22
`define OFL_OP_MOV_STK 8'hf9
`define OFL_OP_ED_PREFIX 8'hed
`define OFL_OP_ED_STORE 8'h43
`define OFL_OP_ED_STORE_MASK 8'hcf
`define OFL_OP_IDX_PREFIX 8'hdd
`define OFL_OP_IDX_MASK 8'hdf
`define OFL_OP_ALU_MASK 8'he0
`define OFL_OP_ALU_BASE 8'h80
// Machine cycle T-state figures
`define OFL_T_FETCH 3'd4
`define OFL_T_MEM 3'd3
`define OFL_T_SPLD 3'd6
// Decimal adjust corrections
`define OFL_DA_NONE 8'h00
`define OFL_DA_ADD_LO 8'h06
`define OFL_DA_ADD_HI 8'h60
`define OFL_DA_ADD_BOTH 8'h66
`define OFL_DA_SUB_LO 8'hfa
`define OFL_DA_SUB_HI 8'ha0
`define OFL_DA_SUB_BOTH 8'h9a
// Restart vector step
`define OFL_RST_SHIFT 3
`endif

//--- rtl/ofl_pkg.sv
// Types for the operand-field decoder
package ofl_pkg;
   typedef enum logic [2:0] {
      OFL_ALU_ADD = 3'h0,
      OFL_ALU_ADC = 3'h1,
      OFL_ALU_SUB = 3'h2,
      OFL_ALU_SUBB = 3'h3,
      OFL_ALU_DECADJ = 3'h4
   } ofl_alu_op_t;
   typedef enum logic [2:0] {
      OFL_REG_PAIR0 = 3'h0,
      OFL_REG_PAIR1 = 3'h1,
      OFL_REG_PAIR2 = 3'h2,
      OFL_REG_STK = 3'h3,
      OFL_REG_ACCF = 3'h4,
      OFL_REG_IDX0 = 3'h5,
      OFL_REG_IDX1 = 3'h6
   } ofl_pair_t;
   typedef enum logic [6:0] {
      OFL_ST_FETCH = 7'b0000001,
      OFL_ST_PFX = 7'b0000010,
      OFL_ST_LO = 7'b0000100,
      OFL_ST_HI = 7'b0001000,
      OFL_ST_WRLO = 7'b0010000,
      OFL_ST_WRHI = 7'b0100000,
      OFL_ST_SPX = 7'b1000000
   } ofl_state_t;
endpackage

//--- rtl/ofl_alu_if.sv
// Operand and result bundle between the sequencer and the 8-bit arithmetic unit
`timescale 1ns/1ns
`default_nettype none
interface ofl_alu_if;
   ofl_pkg::ofl_alu_op_t op;
   logic [7:0] acc;
   logic [7:0] operand;
   logic [7:0] flags_in;
   logic [7:0] result;
   logic [7:0] flags_out;
   modport seq (output op, output acc, output operand, output flags_in, input result, input flags_out);
   modport alu (input op, input acc, input operand, input flags_in, output result, output flags_out);
endinterface
`default_nettype wire

//--- rtl/ofl_alu.sv
// Combinational 8-bit add, subtract and decimal adjust with flag generation
`timescale 1ns/1ns
`default_nettype none
`include "ofl_cfg.svh"
module ofl_alu (
   ofl_alu_if.alu a
);
   logic [4:0] lo;
   logic [8:0] full;
   logic [7:0] sum;
   logic cin;
   logic sub;
   logic [7:0] corr;
   logic dcarry;
   logic [7:0] f;

   // ----------------------------------------
   // Arithmetic
   // ----------------------------------------
   always_comb begin
      f = a.flags_in;
      sub = (a.op == ofl_pkg::OFL_ALU_SUB) || (a.op == ofl_pkg::OFL_ALU_SUBB);
      cin = ((a.op == ofl_pkg::OFL_ALU_ADC) || (a.op == ofl_pkg::OFL_ALU_SUBB)) && a.flags_in[`OFL_FLAG_C];
      corr = `OFL_DA_NONE;
      dcarry = 1'b0;
      lo = 5'h00;
      full = 9'h000;
      sum = 8'h00;
      if (a.op == ofl_pkg::OFL_ALU_DECADJ) begin
         if (!a.flags_in[`OFL_FLAG_N]) begin
            dcarry = a.flags_in[`OFL_FLAG_C] || (a.acc > 8'h99);
            corr = {dcarry ? 4'h6 : 4'h0, (a.flags_in[`OFL_FLAG_H] || a.acc[3:0] > 4'h9) ? 4'h6 : 4'h0};
         end else begin
            dcarry = a.flags_in[`OFL_FLAG_C];
            unique case ({a.flags_in[`OFL_FLAG_C], a.flags_in[`OFL_FLAG_H]})
               2'b00: corr = `OFL_DA_NONE;
               2'b01: corr = `OFL_DA_SUB_LO;
               2'b10: corr = `OFL_DA_SUB_HI;
               2'b11: corr = `OFL_DA_SUB_BOTH;
            endcase
         end
         sum = a.acc + corr;
         f[`OFL_FLAG_C] = dcarry;
         f[`OFL_FLAG_H] = a.flags_in[`OFL_FLAG_N] ? (a.flags_in[`OFL_FLAG_H] && a.acc[3:0] < 4'h6)
                                                  : (a.acc[3:0] > 4'h9);
         f[`OFL_FLAG_PV] = ~^sum;
      end else begin
         if (sub) begin
            lo = {1'b0, a.acc[3:0]} - {1'b0, a.operand[3:0]} - {4'h0, cin};
            full = {1'b0, a.acc} - {1'b0, a.operand} - {8'h00, cin};
         end else begin
            lo = {1'b0, a.acc[3:0]} + {1'b0, a.operand[3:0]} + {4'h0, cin};
            full = {1'b0, a.acc} + {1'b0, a.operand} + {8'h00, cin};
         end
         sum = full[7:0];
         f[`OFL_FLAG_H] = lo[4];
         f[`OFL_FLAG_C] = full[8];
         f[`OFL_FLAG_N] = sub;
         f[`OFL_FLAG_PV] = sub ? ((a.acc[7] != a.operand[7]) && (sum[7] != a.acc[7]))
                               : ((a.acc[7] == a.operand[7]) && (sum[7] != a.acc[7]));
      end
      f[`OFL_FLAG_S] = sum[7];
      f[`OFL_FLAG_Z] = (sum == 8'h00);
      a.result = sum;
      a.flags_out = f;
   end
endmodule
`default_nettype wire

//--- tb/ofl_core_sva.sv
// Checker for the operand-field decoder core ports
`timescale 1ns/1ns
`default_nettype none
module ofl_core_sva (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [7:0] byte_in,
   input wire logic [2:0] cond_field,
   input wire logic [1:0] rel_cond_field,
   input wire logic [2:0] rst_field,
   input wire logic [1:0] pair_field_stack,
   input wire logic [7:0] flags,
   input wire logic [2:0] byte_sel,
   input wire logic [2:0] stack_pair_sel,
   input wire logic cond_true,
   input wire logic rel_cond_true,
   input wire logic [15:0] rst_target,
   input wire logic mem_wr,
   input wire logic [15:0] mem_addr,
   input wire logic mcycle_done
);
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   function automatic logic fsel(input logic [7:0] f, input logic [1:0] s);
      return s == 2'h0 ? f[6] : s == 2'h1 ? f[0] : s == 2'h2 ? f[2] : f[7];
   endfunction
   sequence s_wr_pair;
      mem_wr ##3 mem_wr;
   endsequence
   property p_byte_sel;
      !sys_rst |=> byte_sel == $past(byte_in[2:0]);
   endproperty
   property p_cond;
      !sys_rst |=> cond_true == (fsel($past(flags), $past(cond_field[2:1])) == $past(cond_field[0]));
   endproperty
   property p_rel_cond;
      !sys_rst |=> rel_cond_true == (fsel($past(flags), {1'b0, $past(rel_cond_field[1])}) == $past(rel_cond_field[0]));
   endproperty
   property p_stack_sel;
      !sys_rst |=> stack_pair_sel == ($past(pair_field_stack) == 2'h3 ? 3'h4 : {1'b0, $past(pair_field_stack)});
   endproperty
   property p_rst_vec;
      !sys_rst |=> rst_target == {10'h000, $past(rst_field), 3'h0};
   endproperty
   property p_wr_pair;
      s_wr_pair |-> mem_addr == $past(mem_addr, 3) + 16'h0001;
   endproperty
   property p_wr_gap;
      mem_wr |=> !mem_wr [*2];
   endproperty
   property p_mc_gap;
      mcycle_done |=> !mcycle_done ##1 !mcycle_done;
   endproperty
   a_byte_sel: assert property (p_byte_sel) else $error("byte select mismatch");
   a_cond: assert property (p_cond) else $error("condition result mismatch");
   a_rel_cond: assert property (p_rel_cond) else $error("relative condition mismatch");
   a_stack_sel: assert property (p_stack_sel) else $error("stack pair select mismatch");
   a_rst_vec: assert property (p_rst_vec) else $error("restart target mismatch");
   a_wr_pair: assert property (p_wr_pair) else $error("second write not at next address");
   a_wr_gap: assert property (p_wr_gap) else $error("write cycles too close");
   a_mc_gap: assert property (p_mc_gap) else $error("machine cycle too short");
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the operand-field decoder core
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic mclk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, byte_valid = 1'b1, adjust_req = 1'b0;
   logic [7:0] byte_in = 8'h00, byte_reg_in = 8'h00, accum, flags, mem_wdata, acc = 8'h00, fl = 8'h00;
   logic [2:0] cond_field = 3'h0, rst_field = 3'h0, byte_sel, stack_pair_sel, t_states;
   logic [1:0] rel_cond_field = 2'h0, pair_field_stack = 2'h0;
   logic byte_ready, cond_true, rel_cond_true, mem_wr, mcycle_done, instr_done;
   logic [15:0] pair_zero, pair_one, pair_two, stack_pointer, index_first, index_second, rst_target, mem_addr;
   logic [15:0] pv[6];
   logic [15:0] gq[$];
   logic [23:0] wq[$];
   int n_fail = 0, num_checks = 0, seed = 32'h45c2, gap = 0;
   ofl_core uut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .byte_valid(byte_valid), .byte_in(byte_in),
      .byte_reg_in(byte_reg_in), .cond_field(cond_field), .rel_cond_field(rel_cond_field), .rst_field(rst_field),
      .pair_field_stack(pair_field_stack), .adjust_req(adjust_req), .byte_ready(byte_ready), .accum(accum),
      .flags(flags), .pair_zero(pair_zero), .pair_one(pair_one), .pair_two(pair_two),
      .stack_pointer(stack_pointer), .index_first(index_first), .index_second(index_second),
      .byte_sel(byte_sel), .stack_pair_sel(stack_pair_sel), .cond_true(cond_true),
      .rel_cond_true(rel_cond_true), .rst_target(rst_target), .mem_wr(mem_wr), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .t_states(t_states), .mcycle_done(mcycle_done), .instr_done(instr_done));
   // ----------------------
   // Clock and port monitor
   // ----------------------
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (sys_rst) gap <= 0;
      else if (mcycle_done === 1'b1) begin
         gq.push_back(16'(gap + 1) | 16'(t_states) << 12 | 16'({byte_ready, instr_done}) << 8);
         gap <= 0;
      end else gap <= gap + 1;
      if (mem_wr === 1'b1) wq.push_back({mem_addr, mem_wdata});
   end
   // ----------------
   // Model and checks
   // ----------------
   function automatic logic [15:0] alu(input int op, input logic [7:0] a, input logic [7:0] b, input logic [7:0] f);
      logic [8:0] s;
      logic h;
      logic v;
      logic c;
      c = op[0] & f[0];
      if (op < 2) begin
         s = a + b + c;
         h = (a[3:0] + b[3:0] + c) > 5'h0f;
         v = (a[7] == b[7]) && (s[7] != a[7]);
      end else begin
         s = a - b - c;
         h = {1'b0, a[3:0]} < b[3:0] + c;
         v = (a[7] != b[7]) && (s[7] != a[7]);
      end
      return {s[7:0], s[7], s[7:0] == 8'h00, 1'b0, h, 1'b0, v, op > 1, s[8]};
   endfunction
   function automatic logic cnd(input logic [2:0] c);
      return (c[2:1] == 2'h0 ? fl[6] : c[2:1] == 2'h1 ? fl[0] : c[2:1] == 2'h2 ? fl[2] : fl[7]) == c[0];
   endfunction
   function automatic logic [7:0] bcd(input int d);
      return 8'((d / 10) * 16 + d % 10);
   endfunction
   function automatic logic [15:0] pick(input int s);
      case (s)
         0: return pair_zero;
         1: return pair_one;
         2: return pair_two;
         3: return stack_pointer;
         4: return index_first;
         default: return index_second;
      endcase
   endfunction
   task automatic summarize();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [23:0] e, input logic [23:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic run(input int n, input logic [47:0] b, input logic [23:0] l, input int nw,
      input logic [15:0] wa, input logic [15:0] wd);
      int k;
      logic [7:0] fm;
      logic [23:0] e;
      fm = (b[7:0] == 8'h27) ? 8'hc5 : 8'hd7;
      gq.delete();
      wq.delete();
      for (k = 0; k < n; k++) begin
         byte_in = b[8*k +: 8];
         adjust_req = (k == 0 && b[7:0] == 8'h27);
         repeat (l[4*k +: 4]) @(posedge mclk);
         @(negedge mclk);
      end
      byte_in = 8'h00;
      adjust_req = 1'b0;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      check("accum", {16'h0, acc}, {16'h0, accum});
      check("flags", {16'h0, fl & fm}, {16'h0, flags & fm});
      check("writes", 24'(nw), 24'(wq.size()));
      if (gq.size() < n) check("pulses", 24'(n), 24'(gq.size()));
      for (k = 0; k < n && gq.size() >= n; k++) begin
         e = 24'(l[4*k +: 4]) * 24'h1001 | 24'h200 | 24'(k == n - 1) << 8;
         check("cycle_len", e, 24'(gq[gq.size() - n + k]));
      end
      if (nw == 2 && wq.size() == 2) begin
         check("write_lo", {wa, wd[7:0]}, wq[0]);
         check("write_hi", {wa + 16'h0001, wd[15:8]}, wq[1]);
      end
   endtask
   task automatic alu_op(input int op, input logic [2:0] r, input logic [7:0] v);
      logic [15:0] e;
      e = alu(op, acc, v, fl);
      acc = e[15:8];
      fl = e[7:0];
      byte_reg_in = v;
      run(1, {40'h0, 8'h80 | 8'(op << 3) | {5'h00, r}}, 24'h4, 0, 16'h0, 16'h0);
   endtask
   task automatic cond_scan();
      int i;
      for (i = 0; i < 8; i++) begin
         cond_field = 3'(i);
         rel_cond_field = 2'(i);
         rst_field = 3'(i);
         pair_field_stack = 2'(i);
         repeat (2) @(posedge mclk);
         @(negedge mclk);
         check("cond", 24'(cnd(3'(i))), 24'(cond_true));
         check("rel_cond", 24'(cnd({1'b0, 2'(i)})), 24'(rel_cond_true));
         check("rst_target", 24'(i * 8), 24'(rst_target));
         check("stack_sel", i % 4 == 3 ? 24'h4 : 24'(i % 4), 24'(stack_pair_sel));
      end
   endtask
   initial begin
      repeat (100000) @(posedge mclk);
      n_fail++;
      summarize();
   end
   // -------------
   // Main sequence
   // -------------
   initial begin
      int i;
      int x;
      int y;
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      sys_rst = 1'b0;
      check("reset", 24'h0, {accum, pair_zero});
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      alu_op(0, 3'h1, 8'h7f);
      alu_op(0, 3'h2, 8'h01);
      alu_op(3, 3'h3, 8'h81);
      for (i = 0; i < 40; i++) begin
         alu_op($random(seed) & 3, 3'(($random(seed) & 32'hff) % 6), 8'($random(seed)));
         cond_scan();
      end
      for (i = 0; i < 24; i++) begin
         x = i < 2 ? 99 * (1 - i) : ($random(seed) & 32'hffff) % 100;
         y = i < 2 ? 1 : ($random(seed) & 32'hffff) % 100;
         alu_op(2, 3'h0, acc);
         alu_op(0, 3'h1, bcd(x));
         alu_op((i % 2) * 2, 3'h2, bcd(y));
         acc = bcd((i % 2 == 1) ? (x - y + 100) % 100 : (x + y) % 100);
         fl = {acc[7], acc == 8'h00, 3'h0, ~^acc, fl[1], (i % 2 == 1) ? (x < y) : (x + y > 99)};
         run(1, 48'h27, 24'h4, 0, 16'h0, 16'h0);
      end
      alu_op(2, 3'h0, acc);
      for (i = 0; i < 4; i++) begin
         x = $random(seed);
         y = $random(seed);
         pv[i] = 16'(x);
         run(3, {24'h0, 16'(x), 8'h01 | 8'(i << 4)}, 24'h334, 0, 16'h0, 16'h0);
         check("pair", {8'h00, pv[i]}, {8'h00, pick(i)});
         run(6, {16'h0, 16'(y), 8'h43 | 8'(i << 4), 8'hed}, 24'h333344, 2, 16'(y), pv[i]);
      end
      for (i = 0; i < 2; i++) begin
         x = $random(seed);
         y = $random(seed);
         run(4, {16'h0, 16'(x), 8'h21, 8'hdd | 8'(i << 5)}, 24'h3344, 0, 16'h0, 16'h0);
         check("index", 24'(x & 32'hffff), {8'h00, pick(4 + i)});
         run(6, {16'h0, 16'(y), 8'h22, 8'hdd | 8'(i << 5)}, 24'h333344, 2, 16'(y), 16'(x));
         run(2, {32'h0, 8'hf9, 8'hdd | 8'(i << 5)}, 24'h64, 0, 16'h0, 16'h0);
         check("sp_index", 24'(x & 32'hffff), {8'h00, stack_pointer});
      end
      x = $random(seed);
      run(5, {24'h0, 16'(x), 8'h22}, 24'h33334, 2, 16'(x), pv[2]);
      run(1, 48'hf9, 24'h6, 0, 16'h0, 16'h0);
      check("sp_pair", {8'h00, pv[2]}, {8'h00, stack_pointer});
      summarize();
   end
endmodule
bind ofl_core ofl_core_sva u_sva (.mclk(mclk), .sys_rst(sys_rst), .byte_in(byte_in), .cond_field(cond_field),
   .rel_cond_field(rel_cond_field), .rst_field(rst_field), .pair_field_stack(pair_field_stack), .flags(flags),
   .byte_sel(byte_sel), .stack_pair_sel(stack_pair_sel), .cond_true(cond_true), .rel_cond_true(rel_cond_true),
   .rst_target(rst_target), .mem_wr(mem_wr), .mem_addr(mem_addr), .mcycle_done(mcycle_done));
`default_nettype wire
